/* logic/rsc_reset_strap_config.sv */
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/100ps
`include "rsc_defs.svh"
// Behaviour
// - Security strap low gives two security states, high gives one.
// - Security strap level reads back as read-only disable bit in control register.
// - Monolithic builds take distributor page bits 16 and up from strap.
// - One removal bit per core; a set bit excludes that core.
// - Removal strap present only in strap identity mode.
// - Per-core affinity fields concatenated; present in strap mode with nonzero width.
// - Level 2 and 3 straps dropped when used to select chips.
// - Monolithic builds take the doorbell register page from a strap.
// - Per service compare write address page; only matches raise a request.
// - Match page straps exist only with the bypass switch option.
// - Device identifier taken for doorbell writes, ignored otherwise.
// - Eleven-bit strap sets each collator base when signal-based.
module rsc_reset_strap_config #(
  parameter int CORE_COUNT = 4,
  parameter int ADDR_W = 48,
  parameter int L0_W = 8,
  parameter int L1_W = 8,
  parameter int L2_W = 8,
  parameter int L3_W = 8,
  parameter bit STRAP_ID_MODE = 1'b1,
  parameter bit L2_SELECTS_CHIP = 1'b0,
  parameter bit L3_SELECTS_CHIP = 1'b0,
  parameter bit MONOLITHIC = 1'b1,
  parameter bit BYPASS_SWITCH = 1'b1,
  parameter int SERVICE_COUNT = 2,
  parameter bit SPI_BASE_BY_SIGNAL = 1'b1,
  parameter int COLLATOR_COUNT = 2,
  parameter int DEVID_W = 32,
  parameter logic [15:0] DIST_PAGE_PARAM = 16'h0000,
  parameter logic [15:0] DOORBELL_PAGE_PARAM = 16'h0001
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Tie-off straps
  input wire logic security_disable_strap,
  input wire logic [15:0] dist_page_strap,
  input wire logic [CORE_COUNT-1:0] core_removal_strap,
  input wire logic [CORE_COUNT*L0_W-1:0] level0_core_id_strap,
  input wire logic [CORE_COUNT*L1_W-1:0] level1_core_id_strap,
  input wire logic [CORE_COUNT*L2_W-1:0] level2_core_id_strap,
  input wire logic [CORE_COUNT*L3_W-1:0] level3_core_id_strap,
  input wire logic [15:0] doorbell_page_strap,
  input wire logic [15:0] wide_doorbell_page_strap,
  input wire logic [SERVICE_COUNT*(ADDR_W-16)-1:0] match_page_strap,
  input wire logic [COLLATOR_COUNT*`RSC_SPI_BASE_W-1:0] spi_base_strap,
  // Interconnect write address channel, observed
  input wire logic awvalid_in,
  input wire logic awready_in,
  input wire logic [ADDR_W-1:0] awaddr_in,
  input wire logic [DEVID_W-1:0] awdeviceid,
  // Applied configuration
  output logic two_security_states,
  output logic [15:0] dist_page,
  output logic [15:0] doorbell_page,
  output logic [CORE_COUNT-1:0] core_enabled,
  output logic [CORE_COUNT*L0_W-1:0] level0_core_id,
  output logic [CORE_COUNT*L1_W-1:0] level1_core_id,
  output logic [CORE_COUNT*L2_W-1:0] level2_core_id,
  output logic [CORE_COUNT*L3_W-1:0] level3_core_id,
  output logic [COLLATOR_COUNT*`RSC_SPI_BASE_W-1:0] spi_base,
  // Doorbell requests
  output logic [SERVICE_COUNT-1:0] msi_req,
  output logic [DEVID_W-1:0] msi_devid,
  // AXI4-Lite register slave
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  localparam int PW = ADDR_W - `RSC_PAGE_LSB;

  // Straps are not synchronous to mclk: two flops before the security bit is used
  logic [1:0] cap_q, cap_d;
  logic ds_q, ds_d;
  logic [15:0] dpage_q, dpage_d, dbpage_q, dbpage_d, wpage_q, wpage_d;
  logic [CORE_COUNT-1:0] rm_q, rm_d;
  logic [CORE_COUNT*L0_W-1:0] a0_q, a0_d;
  logic [CORE_COUNT*L1_W-1:0] a1_q, a1_d;
  logic [CORE_COUNT*L2_W-1:0] a2_q, a2_d;
  logic [CORE_COUNT*L3_W-1:0] a3_q, a3_d;
  logic [SERVICE_COUNT*PW-1:0] mp_q, mp_d;
  logic [COLLATOR_COUNT*`RSC_SPI_BASE_W-1:0] sb_q, sb_d;
  logic ds_s1_q, ds_s2_q;

  // Wide straps are captured on the second edge after release; the security
  // bit waits one edge more, until its synchroniser holds the pin level.
  // Afterwards the captured copy never changes.
  always_comb begin
    cap_d = cap_q;
    ds_d = ds_q;
    dpage_d = dpage_q;
    dbpage_d = dbpage_q;
    wpage_d = wpage_q;
    rm_d = rm_q;
    a0_d = a0_q;
    a1_d = a1_q;
    a2_d = a2_q;
    a3_d = a3_q;
    mp_d = mp_q;
    sb_d = sb_q;
    if (cap_q != 2'h3) begin
      cap_d = cap_q + 2'h1;
    end
    if (cap_q == 2'h2) begin
      ds_d = ds_s2_q;
    end
    if (cap_q == 2'h1) begin
      dpage_d = MONOLITHIC ? dist_page_strap : DIST_PAGE_PARAM;
      dbpage_d = MONOLITHIC ? doorbell_page_strap : DOORBELL_PAGE_PARAM;
      wpage_d = wide_doorbell_page_strap;
      rm_d = STRAP_ID_MODE ? core_removal_strap : '0;
      a0_d = (STRAP_ID_MODE && L0_W != 0) ? level0_core_id_strap : '0;
      a1_d = (STRAP_ID_MODE && L1_W != 0) ? level1_core_id_strap : '0;
      a2_d = (STRAP_ID_MODE && L2_W != 0 && !L2_SELECTS_CHIP) ? level2_core_id_strap : '0;
      a3_d = (STRAP_ID_MODE && L3_W != 0 && !L3_SELECTS_CHIP) ? level3_core_id_strap : '0;
      mp_d = BYPASS_SWITCH ? match_page_strap : '0;
      sb_d = SPI_BASE_BY_SIGNAL ? spi_base_strap : '0;
    end
  end

  // Only the security bit is a single level; the wide buses are
  // captured once, two edges late, when they are long settled.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ds_s1_q <= 1'b0;
      ds_s2_q <= 1'b0;
      cap_q <= 2'h0;
      ds_q <= 1'b0;
      dpage_q <= '0;
      dbpage_q <= '0;
      wpage_q <= '0;
      rm_q <= '0;
      a0_q <= '0;
      a1_q <= '0;
      a2_q <= '0;
      a3_q <= '0;
      mp_q <= '0;
      sb_q <= '0;
    end else begin
      ds_s1_q <= security_disable_strap;
      ds_s2_q <= ds_s1_q;
      cap_q <= cap_d;
      ds_q <= ds_d;
      dpage_q <= dpage_d;
      dbpage_q <= dbpage_d;
      wpage_q <= wpage_d;
      rm_q <= rm_d;
      a0_q <= a0_d;
      a1_q <= a1_d;
      a2_q <= a2_d;
      a3_q <= a3_d;
      mp_q <= mp_d;
      sb_q <= sb_d;
    end
  end

  assign two_security_states = ~ds_q;
  assign dist_page = dpage_q;
  assign doorbell_page = dbpage_q;
  assign core_enabled = ~rm_q;
  assign level0_core_id = a0_q;
  assign level1_core_id = a1_q;
  assign level2_core_id = a2_q;
  assign level3_core_id = a3_q;
  assign spi_base = sb_q;

  // Doorbell page match per service
  logic match_en_q, match_en_d;
  logic [SERVICE_COUNT-1:0] hit;
  logic [SERVICE_COUNT-1:0] req_q, req_d;
  logic [DEVID_W-1:0] devid_q, devid_d;
  logic [15:0] mcount_q, mcount_d;
  logic aw_fire;
  assign aw_fire = awvalid_in && awready_in && (cap_q == 2'h3);

  genvar gs;
  generate
    for (gs = 0; gs < SERVICE_COUNT; gs++) begin : g_svc
      assign hit[gs] = aw_fire && match_en_q &&
        (awaddr_in[ADDR_W-1:`RSC_PAGE_LSB] == mp_q[gs*PW +: PW]);
    end
  endgenerate

  always_comb begin
    req_d = BYPASS_SWITCH ? hit : '0;
    devid_d = devid_q;
    mcount_d = mcount_q;
    if (|req_d) begin
      devid_d = awdeviceid;
      mcount_d = mcount_q + 16'h0001;
    end
  end

  assign msi_req = req_q;
  assign msi_devid = devid_q;

  // Register slave
  rsc_pkg::rsc_wstate_t ws_q, ws_d;
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [11:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic [11:0] wa;

  assign s_awready = (ws_q != rsc_pkg::RSC_W_RESP) && !aw_got_q;
  assign s_wready = (ws_q != rsc_pkg::RSC_W_RESP) && !w_got_q;
  assign s_bvalid = (ws_q == rsc_pkg::RSC_W_RESP);
  assign s_bresp = bresp_q;
  assign s_arready = !rvalid_q;
  assign s_rvalid = rvalid_q;
  assign s_rdata = rdata_q;
  assign s_rresp = rresp_q;

  always_comb begin
    ws_d = ws_q;
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    bresp_d = bresp_q;
    match_en_d = match_en_q;
    wa = aw_got_q ? waddr_q : s_awaddr;
    case (ws_q)
      rsc_pkg::RSC_W_IDLE, rsc_pkg::RSC_W_HALF: begin
        if (s_awvalid && s_awready) begin
          aw_got_d = 1'b1;
          waddr_d = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
          w_got_d = 1'b1;
          wdata_d = s_wdata;
        end
        if (aw_got_d && w_got_d) begin
          ws_d = rsc_pkg::RSC_W_RESP;
          aw_got_d = 1'b0;
          w_got_d = 1'b0;
          bresp_d = rsc_pkg::RSC_RESP_SLVERR;
          if (wa == `RSC_OFF_MATCH_CTRL) begin
            bresp_d = rsc_pkg::RSC_RESP_OKAY;
            if (w_got_q ? 1'b1 : s_wstrb[0]) begin
              match_en_d = w_got_q ? wdata_q[`RSC_MATCH_EN_BIT]
                                   : s_wdata[`RSC_MATCH_EN_BIT];
            end
          end else if (wa < `RSC_OFF_SPI_BASE0 + 12'(COLLATOR_COUNT * 4)) begin
            // Strap-backed registers are read-only; writes are dropped
            bresp_d = rsc_pkg::RSC_RESP_OKAY;
          end
        end else if (aw_got_d || w_got_d) begin
          ws_d = rsc_pkg::RSC_W_HALF;
        end
      end
      rsc_pkg::RSC_W_RESP: begin
        if (s_bready) begin
          ws_d = rsc_pkg::RSC_W_IDLE;
        end
      end
      default: ws_d = rsc_pkg::RSC_W_IDLE;
    endcase
  end

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && s_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_arvalid && s_arready) begin
      rvalid_d = 1'b1;
      rresp_d = rsc_pkg::RSC_RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (s_araddr == `RSC_OFF_DIST_CTRL) begin
        rdata_d[`RSC_DS_BIT] = ds_q;
        rdata_d[`RSC_SEC_BOTH_BIT] = ~ds_q;
      end else if (s_araddr == `RSC_OFF_STATUS) begin
        rdata_d[`RSC_ALL_OFF_BIT] = &rm_q;
        rdata_d[`RSC_CAPTURED_BIT] = (cap_q == 2'h3);
      end else if (s_araddr == `RSC_OFF_DIST_PAGE) begin
        rdata_d[15:0] = dpage_q;
      end else if (s_araddr == `RSC_OFF_DOORBELL_PAGE) begin
        rdata_d[15:0] = dbpage_q;
      end else if (s_araddr == `RSC_OFF_WIDE_PAGE) begin
        rdata_d[15:0] = wpage_q;
      end else if (s_araddr == `RSC_OFF_CORE_REMOVAL) begin
        rdata_d[CORE_COUNT-1:0] = rm_q;
      end else if (s_araddr == `RSC_OFF_MATCH_CTRL) begin
        rdata_d[`RSC_MATCH_EN_BIT] = match_en_q;
      end else if (s_araddr == `RSC_OFF_MATCH_COUNT) begin
        rdata_d[15:0] = mcount_q;
      end else if (s_araddr == `RSC_OFF_LAST_DEVID) begin
        rdata_d[DEVID_W-1:0] = devid_q;
      end else if (s_araddr >= `RSC_OFF_SPI_BASE0 &&
                   s_araddr < `RSC_OFF_SPI_BASE0 + 12'(COLLATOR_COUNT * 4) &&
                   s_araddr[1:0] == 2'b00) begin
        rdata_d[`RSC_SPI_BASE_W-1:0] =
          sb_q[(s_araddr - `RSC_OFF_SPI_BASE0) / 4 * `RSC_SPI_BASE_W +: `RSC_SPI_BASE_W];
      end else begin
        rresp_d = rsc_pkg::RSC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ws_q <= rsc_pkg::RSC_W_IDLE;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      waddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      bresp_q <= 2'b00;
      match_en_q <= 1'(`RSC_MATCH_CTRL_RESET);
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'b00;
      req_q <= '0;
      devid_q <= '0;
      mcount_q <= 16'h0000;
    end else begin
      ws_q <= ws_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      bresp_q <= bresp_d;
      match_en_q <= match_en_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      req_q <= req_d;
      devid_q <= devid_d;
      mcount_q <= mcount_d;
    end
  end

  // Checks
  sequence s_page_write;
    aw_fire && match_en_q && BYPASS_SWITCH &&
      (awaddr_in[ADDR_W-1:`RSC_PAGE_LSB] == mp_q[PW-1:0]);
  endsequence

  a_page_match_req: assert property (@(posedge mclk) disable iff (!reset_n)
    s_page_write |=> msi_req[0]) else $error("page match gave no request");
  a_no_match_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
    !aw_fire |=> (msi_req == '0)) else $error("request without write");
  a_devid_taken: assert property (@(posedge mclk) disable iff (!reset_n)
    s_page_write |=> (msi_devid == $past(awdeviceid))) else $error("device id not taken");
  a_devid_ignored: assert property (@(posedge mclk) disable iff (!reset_n)
    (msi_req == '0) |-> $stable(msi_devid)) else $error("device id moved on non-doorbell");
  a_security_mode: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(cap_q == 2'h3) |-> (two_security_states == !$past(ds_s2_q)))
    else $error("security mode mismatch");
  a_ds_readback: assert property (@(posedge mclk) disable iff (!reset_n)
    (s_arvalid && s_arready && s_araddr == `RSC_OFF_DIST_CTRL) |=>
      (s_rvalid && s_rdata[`RSC_DS_BIT] == $past(ds_q))) else $error("security bit readback");
  a_core_removed: assert property (@(posedge mclk) disable iff (!reset_n)
    (cap_q == 2'h1) |=>
      (core_enabled == (STRAP_ID_MODE ? ~$past(core_removal_strap) : '1)))
    else $error("core removal not applied");
  a_strap_frozen: assert property (@(posedge mclk) disable iff (!reset_n)
    (cap_q == 2'h3) |=> ($stable(dist_page) && $stable(level0_core_id) && $stable(spi_base)))
    else $error("captured straps changed");
  a_capture_time: assert property (@(posedge mclk) disable iff (!reset_n)
    (cap_q == 2'h1) |=> (dist_page == (MONOLITHIC ? $past(dist_page_strap) : DIST_PAGE_PARAM)))
    else $error("distributor page not captured");
  a_write_resp: assert property (@(posedge mclk) disable iff (!reset_n)
    (s_bvalid && !s_bready) |=> s_bvalid) else $error("write response dropped");
endmodule : rsc_reset_strap_config

/* logic/rsc_defs.svh */
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH
// Register byte offsets
`define RSC_OFF_DIST_CTRL 12'h000
`define RSC_OFF_STATUS 12'h004
`define RSC_OFF_DIST_PAGE 12'h008
`define RSC_OFF_DOORBELL_PAGE 12'h00c
`define RSC_OFF_WIDE_PAGE 12'h010
`define RSC_OFF_CORE_REMOVAL 12'h014
`define RSC_OFF_MATCH_CTRL 12'h018
`define RSC_OFF_MATCH_COUNT 12'h01c
`define RSC_OFF_LAST_DEVID 12'h020
`define RSC_OFF_SPI_BASE0 12'h024
// Field positions
`define RSC_DS_BIT 0
`define RSC_SEC_BOTH_BIT 1
`define RSC_ALL_OFF_BIT 0
`define RSC_CAPTURED_BIT 1
`define RSC_MATCH_EN_BIT 0
// Page boundary: 64K pages start at address bit 16
`define RSC_PAGE_LSB 16
`define RSC_SPI_BASE_W 11
`define RSC_MATCH_CTRL_RESET 32'h0000_0001
`endif

/* logic/rsc_pkg.sv */
package rsc_pkg;
  typedef enum logic [1:0] {
    RSC_RESP_OKAY = 2'b00,
    RSC_RESP_SLVERR = 2'b10
  } rsc_resp_t;
  typedef enum logic [2:0] {
    RSC_W_IDLE = 3'b001,
    RSC_W_HALF = 3'b010,
    RSC_W_RESP = 3'b100
  } rsc_wstate_t;
endpackage : rsc_pkg

/* bench/rsc_far_end.sv */
`timescale 1ns/100ps
module rsc_far_end #(
  parameter int ADDR_W = 48
) (
  // Clock
  input wire logic mclk,
  // Observed write address channel
  output logic awvalid_in,
  output logic awready_in,
  output logic [ADDR_W-1:0] awaddr_in,
  output logic [31:0] awdeviceid
);
  initial begin
    awvalid_in = 1'b0;
    awready_in = 1'b0;
    awaddr_in = '0;
    awdeviceid = '0;
  end

  // Released payload is inverted so a stale address can never match a page
  task automatic send(input logic [ADDR_W-1:0] a, input logic [31:0] id, input int stall);
    @(posedge mclk);
    awvalid_in <= 1'b1;
    awaddr_in <= a;
    awdeviceid <= id;
    awready_in <= (stall == 0);
    if (stall != 0) begin
      repeat (stall) @(posedge mclk);
      awready_in <= 1'b1;
    end
    @(posedge mclk);
    awvalid_in <= 1'b0;
    awready_in <= 1'b0;
    awaddr_in <= ~a;
    awdeviceid <= ~id;
  endtask : send
endmodule : rsc_far_end

/* bench/rsc_reset_strap_config_bench.sv */
`timescale 1ns/100ps
`include "rsc_defs.svh"
module rsc_reset_strap_config_bench;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic security_disable_strap = 1'b1;
  logic [15:0] dist_page_strap = 16'h00a5;
  // Nonzero and apart from the wide page
  logic [15:0] doorbell_page_strap = 16'h0b3c;
  logic [15:0] wide_doorbell_page_strap = 16'h0c4d;
  // Never every core removed
  logic [3:0] core_removal_strap = 4'h5;
  logic [31:0] level0_core_id_strap = 32'h0302_0100;
  logic [31:0] level1_core_id_strap = 32'h1312_1110;
  logic [31:0] level2_core_id_strap = 32'h2322_2120;
  logic [31:0] level3_core_id_strap = 32'h3332_3130;
  logic [63:0] match_page_strap = 64'h0000_5678_0000_1234;
  logic [21:0] spi_base_strap = {11'h155, 11'h0aa};
  logic awvalid_in, awready_in;
  logic [47:0] awaddr_in;
  logic [31:0] awdeviceid, msi_devid;
  logic two_security_states;
  logic [15:0] dist_page, doorbell_page;
  logic [3:0] core_enabled;
  logic [31:0] level0_core_id, level1_core_id, level2_core_id, level3_core_id;
  logic [21:0] spi_base;
  logic [1:0] msi_req, s_bresp, s_rresp;
  logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
  logic [31:0] s_wdata = 32'h0, s_rdata;
  logic [3:0] s_wstrb = 4'h0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  int n_fail = 0;
  int compares = 0;

  always #2 mclk = ~mclk;

  rsc_reset_strap_config rsc_reset_strap_config_inst (.mclk, .reset_n, .security_disable_strap,
    .dist_page_strap, .core_removal_strap, .level0_core_id_strap, .level1_core_id_strap,
    .level2_core_id_strap, .level3_core_id_strap, .doorbell_page_strap,
    .wide_doorbell_page_strap, .match_page_strap, .spi_base_strap, .awvalid_in, .awready_in,
    .awaddr_in, .awdeviceid, .two_security_states, .dist_page, .doorbell_page, .core_enabled,
    .level0_core_id, .level1_core_id, .level2_core_id, .level3_core_id, .spi_base, .msi_req,
    .msi_devid, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
    .s_rvalid, .s_rready);

  rsc_far_end rsc_far_end_inst (.mclk, .awvalid_in, .awready_in, .awaddr_in, .awdeviceid);

  task automatic conclude;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge mclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hf;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge mclk);
      if (!aw_done && s_awready) begin
        aw_done = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!w_done && s_wready) begin
        w_done = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (!s_bvalid);
    s_bready <= 1'b0;
    chk(s_bresp, rsc_pkg::RSC_RESP_OKAY, "bresp");
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge mclk); while (!s_arready);
    s_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_rvalid);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask : rd

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(r, rsc_pkg::RSC_RESP_OKAY, "rresp");
    chk(d, exp, "rdata");
  endtask : rdchk

  // One observed write, then the pulse must be gone a cycle later
  task automatic db(input logic [47:0] a, input logic [31:0] id, input int stall,
                    input logic [1:0] exp_req, input logic [31:0] exp_id);
    rsc_far_end_inst.send(a, id, stall);
    #1;
    chk(msi_req, exp_req, "msi_req");
    chk(msi_devid, exp_id, "msi_devid");
    @(posedge mclk);
    #1;
    chk(msi_req, 2'b00, "msi_req drop");
  endtask : db

  initial begin
    repeat (3000) @(posedge mclk);
    n_fail++;
    conclude;
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    #1;
    chk(two_security_states, 1'b1, "reset states");
    chk(core_enabled, 4'hf, "reset cores");
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    chk(two_security_states, 1'b0, "states");
    chk(dist_page, 16'h00a5, "dist page");
    chk(doorbell_page, 16'h0b3c, "doorbell page");
    chk(core_enabled, 4'ha, "cores");
    chk(level0_core_id, level0_core_id_strap, "l0");
    chk(level1_core_id, level1_core_id_strap, "l1");
    chk(level2_core_id, level2_core_id_strap, "l2");
    chk(level3_core_id, level3_core_id_strap, "l3");
    chk(spi_base, spi_base_strap, "spi base");
    rdchk(`RSC_OFF_DIST_CTRL, 32'h1);
    wr(`RSC_OFF_DIST_CTRL, 32'h0);
    rdchk(`RSC_OFF_DIST_CTRL, 32'h1);
    rdchk(`RSC_OFF_STATUS, 32'h2);
    rdchk(`RSC_OFF_DIST_PAGE, 32'h00a5);
    rdchk(`RSC_OFF_DOORBELL_PAGE, 32'h0b3c);
    rdchk(`RSC_OFF_WIDE_PAGE, 32'h0c4d);
    rdchk(`RSC_OFF_CORE_REMOVAL, 32'h5);
    rdchk(`RSC_OFF_SPI_BASE0, 32'h0aa);
    rdchk(`RSC_OFF_SPI_BASE0 + 12'h004, 32'h155);
    db({32'h1234, 16'h0040}, 32'hd0d0_0001, 0, 2'b01, 32'hd0d0_0001);
    db({32'h5678, 16'hfffc}, 32'hd0d0_0002, 2, 2'b10, 32'hd0d0_0002);
    db({32'h1235, 16'h0040}, 32'hd0d0_0003, 0, 2'b00, 32'hd0d0_0002);
    rdchk(`RSC_OFF_MATCH_COUNT, 32'h2);
    wr(`RSC_OFF_MATCH_CTRL, 32'h0);
    rdchk(`RSC_OFF_MATCH_CTRL, 32'h0);
    db({32'h1234, 16'h0000}, 32'hd0d0_0004, 1, 2'b00, 32'hd0d0_0002);
    wr(`RSC_OFF_MATCH_CTRL, 32'h1);
    rdchk(`RSC_OFF_MATCH_CTRL, 32'h1);
    rd(12'h100, d, r);
    chk(r, rsc_pkg::RSC_RESP_SLVERR, "unmapped resp");
    chk(d, 32'h0, "unmapped data");
    // Moved after capture on purpose: the applied value must not follow
    dist_page_strap <= 16'h7777;
    core_removal_strap <= 4'h0;
    repeat (4) @(posedge mclk);
    #1;
    chk(dist_page, 16'h00a5, "late page");
    chk(core_enabled, 4'ha, "late cores");
    // A fresh reset must pick up the moved straps
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    chk(dist_page, 16'h7777, "recaptured page");
    chk(core_enabled, 4'hf, "recaptured cores");
    chk(two_security_states, 1'b0, "recaptured states");
    conclude;
  end
endmodule : rsc_reset_strap_config_bench
